//--- src/mrc_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the run control
// Assumes: 32-bit register words, byte addresses
// Notes: included by the run control module
`ifndef MRC_DEFINES_SVH
`define MRC_DEFINES_SVH

// register byte offsets
`define MRC_OFS_MODE 8'h00
`define MRC_OFS_UPPER 8'h04
`define MRC_OFS_LOWER 8'h08
`define MRC_OFS_CMD 8'h0C
`define MRC_OFS_TARGET 8'h10
`define MRC_OFS_TIMEOUT 8'h14
`define MRC_OFS_LOOPLEN 8'h18
`define MRC_OFS_STATUS 8'h1C
`define MRC_OFS_ACTPOS 8'h20
`define MRC_OFS_RUNDIST 8'h24
// run set window: addr[7:6] == 01, addr[5:4] = set, addr[3:2] = word
`define MRC_SET_PAGE 2'h1

// command word bits
`define MRC_CMD_MAN_UP 0
`define MRC_CMD_MAN_DN 1
`define MRC_CMD_POS 2
`define MRC_CMD_SET_LO 8
`define MRC_CMD_SET_HI 9

// status word bits
`define MRC_ST_LINK_OK 0
`define MRC_ST_MOVING 6
`define MRC_ST_POS_ERR 10

// reset values
`define MRC_RST_MODE 3'h0
`define MRC_RST_UPPER 32'h0000_0168
`define MRC_RST_LOWER 32'h0000_0000
`define MRC_RST_TIMEOUT 16'h0000
`define MRC_RST_WINDOW 32'h0000_0001
`define MRC_RST_SPEED 16'h0064
`define MRC_RST_ABORT_PCT 8'h1E
`define MRC_RST_ABORT_MS 16'h00C8
`define MRC_RST_CUR 8'h64
`define MRC_RST_ST_MS 16'h00C8

// timing: one millisecond at the system clock
`define MRC_CLK_NS 50
`define MRC_MS_NS 1000000
`define MRC_MS_CYC (`MRC_MS_NS / `MRC_CLK_NS)

`endif

//--- src/mrc_pkg.sv
// Purpose: types shared by the run control
// Assumes: constants live in mrc_defines.svh
// Notes: none
package mrc_pkg;
  // modulo sub-modes
  typedef enum logic [2:0] {
    MRC_MOD_OFF = 3'h0,
    MRC_MOD_UP = 3'h1,
    MRC_MOD_DN = 3'h2,
    MRC_MOD_SHORT = 3'h3,
    MRC_MOD_UP_WIN = 3'h4,
    MRC_MOD_DN_WIN = 3'h5
  } mrc_mode_t;

  // run sequencer states
  typedef enum logic {MRC_IDLE, MRC_RUN} mrc_state_t;

  // one run parameter set
  typedef struct packed {
    logic [31:0] window;
    logic [15:0] speed;
    logic [15:0] abort_ms;
    logic [7:0] abort_pct;
    logic [7:0] op_cur;
    logic [7:0] st_cur;
    logic [15:0] st_ms;
  } mrc_set_t;

  // start-up values frozen for one run
  typedef struct packed {
    logic [7:0] st_cur;
    logic [15:0] st_ms;
  } mrc_startup_t;
endpackage

//--- src/mrc_run_ctrl.sv
// Purpose: modulo run control with run sets, link supervision and stall abort
// Assumes: AXI4-Lite register access, motor loop outside reports speed and run end
// Notes: positions are signed 32-bit steps
//
// Behaviour
// - modulo width is upper minus lower modulo position, used for folding and distances
// - modulo active: target folded so it differs from command by whole widths
// - reported position stays within lower inclusive and upper exclusive
// - rising past upper minus one, reported value jumps to lower
// - falling below lower, reported value jumps to upper minus one
// - sub-mode 0 disables modulo, continuous targets, and is the reset value
// - sub-mode 1 runs upward only, distance at most width minus one
// - sub-mode 2 runs downward only, distance at most width minus one
// - sub-mode 3 takes the shorter way, never beyond half a width
// - sub-mode 4 as 1, but small downward steps within window go directly
// - sub-mode 5 as 2, but small upward steps within window go directly
// - modulo active ignores range limits and upper mapping end
// - modulo has no reference loop; loop length sign picks readjust direction
// - modulo manual run travels exactly one width in requested direction
// - without modulo option only default values of the modulo settings are accepted
// - command bits 9..8 select run set 1 to 4
// - a set change applies its values at once, even mid-run
// - start-up current and duration change only at the next run start
// - without set switching, command bits 9..8 are ignored
// - zero timeout: link loss lets the run finish, then blocks runs
// - nonzero timeout: no telegram in time aborts run and blocks runs
// - run aborted when speed stays below percentage of target too long
// - manual run from bit 0 or 1; status 6 while moving, 10 on error
`timescale 1ns/1ps
`default_nettype none
`include "mrc_defines.svh"

module mrc_run_ctrl
  import mrc_pkg::*;
#(
  parameter bit HAS_MODULO = 1'b1,
  parameter bit HAS_SETS = 1'b1,
  parameter int MS_CYC = `MRC_MS_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // link supervision
  input wire logic link_up,
  input wire logic telegram_rx,
  // motor loop
  input wire logic signed [31:0] enc_pos,
  input wire logic [15:0] speed_act,
  input wire logic run_done,
  output logic run_start,
  output logic run_active,
  output logic run_abort,
  output logic signed [31:0] run_dist,
  output logic run_manual,
  // parameters handed to the motor loop
  output mrc_set_t set_live,
  output mrc_startup_t startup_live,
  output logic adj_dir_neg,
  output logic ref_loop_en
);

  // modulo fold into [lo, lo + w)
  function automatic logic signed [31:0] fold(input logic signed [31:0] x, lo, w);
    logic signed [31:0] r;
    r = (x - lo) % w;
    return (r < 0) ? r + w + lo : r + lo;
  endfunction
  // register state
  mrc_mode_t mode_ff;
  logic signed [31:0] upper_ff, lower_ff, target_ff, loop_len_ff;
  logic [15:0] cmd_ff, timeout_ff;
  mrc_set_t sets_ff [4];
  mrc_startup_t startup_ff;
  mrc_state_t state_ff;
  logic pos_err_ff, link_lost_ff, done_pend_ff;
  logic [15:0] ms_since_ff, stall_ms_ff;
  logic [$clog2(MS_CYC+1)-1:0] div_ff;
  logic signed [31:0] dist_ff;
  logic manual_ff, start_ff, abort_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  // write decode
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  wire [7:0] wa = s_axi_awaddr;
  wire wr_set = (wa[7:6] == `MRC_SET_PAGE);
  wire [1:0] wr_set_idx = wa[5:4];
  wire [1:0] wr_word = wa[3:2];
  wire wr_mode = (wa == `MRC_OFS_MODE);
  wire wr_upper = (wa == `MRC_OFS_UPPER);
  wire wr_lower = (wa == `MRC_OFS_LOWER);
  wire wr_cmd = (wa == `MRC_OFS_CMD);
  wire wr_target = (wa == `MRC_OFS_TARGET);
  wire wr_tmo = (wa == `MRC_OFS_TIMEOUT);
  wire wr_loop = (wa == `MRC_OFS_LOOPLEN);
  wire wr_known = wr_set || wr_mode || wr_upper || wr_lower || wr_cmd || wr_target
                  || wr_tmo || wr_loop;
  wire signed [31:0] wval = s_axi_wdata;
  // settings checks; a refused write keeps the old value and answers slverr
  wire mode_bad = (s_axi_wdata > 32'h0000_0005)
                  || (!HAS_MODULO && s_axi_wdata != 32'h0000_0000);
  wire upper_bad = (wval <= lower_ff)
                   || (!HAS_MODULO && wval != `MRC_RST_UPPER);
  wire lower_bad = (wval >= upper_ff)
                   || (!HAS_MODULO && wval != `MRC_RST_LOWER);
  wire wr_bad = !wr_known || (wr_mode && mode_bad) || (wr_upper && upper_bad)
                || (wr_lower && lower_bad) || (s_axi_wstrb != 4'hF);
  wire wr_ok = wr_go && !wr_bad;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  // modulo geometry
  wire mod_on = (mode_ff != MRC_MOD_OFF);
  wire signed [31:0] width = upper_ff - lower_ff;
  wire signed [31:0] half_w = width >>> 1;
  wire signed [31:0] act_pos = mod_on ? fold(enc_pos, lower_ff, width)
                                      : enc_pos;
  wire signed [31:0] tgt_pos = mod_on ? fold(target_ff, lower_ff, width)
                                      : target_ff;
  wire signed [31:0] diff = tgt_pos - act_pos;

  // run set selection and live values
  wire [1:0] set_sel = HAS_SETS ? cmd_ff[`MRC_CMD_SET_HI:`MRC_CMD_SET_LO]
                                : 2'h0;
  wire mrc_set_t cur_set = sets_ff[set_sel];
  wire signed [31:0] win = cur_set.window;
  assign set_live = cur_set;
  assign startup_live = startup_ff;

  // distance per sub-mode; no limit or mapping-end clamp in modulo mode
  logic signed [31:0] pos_dist;
  always_comb begin
    pos_dist = diff;
    unique case (mode_ff)
      MRC_MOD_OFF: pos_dist = diff;
      MRC_MOD_UP: pos_dist = (diff < 0) ? diff + width : diff;
      MRC_MOD_DN: pos_dist = (diff > 0) ? diff - width : diff;
      MRC_MOD_SHORT: pos_dist = (diff > half_w) ? diff - width
                                : (diff < -half_w) ? diff + width : diff;
      MRC_MOD_UP_WIN: pos_dist = (diff < 0 && -diff > win) ? diff + width : diff;
      MRC_MOD_DN_WIN: pos_dist = (diff > 0 && diff > win) ? diff - width : diff;
      default: pos_dist = diff;
    endcase
  end

  // command edges start runs
  wire [15:0] cmd_new = s_axi_wdata[15:0];
  wire cmd_wr = wr_ok && wr_cmd;
  wire req_up = cmd_wr && cmd_new[`MRC_CMD_MAN_UP] && !cmd_ff[`MRC_CMD_MAN_UP];
  wire req_dn = cmd_wr && cmd_new[`MRC_CMD_MAN_DN] && !cmd_ff[`MRC_CMD_MAN_DN];
  wire req_pos = cmd_wr && cmd_new[`MRC_CMD_POS] && !cmd_ff[`MRC_CMD_POS];
  wire link_ok = !link_lost_ff;
  wire may_start = (state_ff == MRC_IDLE) && link_ok;
  wire go_man = may_start && (req_up || req_dn);
  wire go_pos = may_start && req_pos && !go_man;
  // manual run: one modulo width, or open-ended (zero) when continuous
  wire signed [31:0] man_dist = !mod_on ? 32'sh0 :
                                req_up ? width : -width;

  // millisecond enable
  wire ms_tick = (div_ff == ($clog2(MS_CYC+1))'(MS_CYC - 1));
  // stall: speed under pct of target; compared scaled by 100 to avoid a divide
  wire [23:0] spd_scaled = {8'h00, speed_act} * 24'd100;
  wire [23:0] spd_limit = {8'h00, cur_set.speed} * {16'h0000, cur_set.abort_pct};
  wire slow = spd_scaled < spd_limit;
  wire stall_hit = (state_ff == MRC_RUN) && slow
                   && (stall_ms_ff > cur_set.abort_ms);

  // link supervision: zero timeout follows the link level, else telegram age
  wire tmo_hit = (timeout_ff != 16'h0000) && (ms_since_ff >= timeout_ff);
  wire lost_now = (timeout_ff == 16'h0000) ? !link_up : tmo_hit;
  wire tmo_abort = (state_ff == MRC_RUN) && (timeout_ff != 16'h0000) && tmo_hit;
  wire abort_now = stall_hit || tmo_abort;

  // reference loop and readjust direction
  assign ref_loop_en = !mod_on && (loop_len_ff != 32'sh0);
  assign adj_dir_neg = loop_len_ff[31];

  // register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= MRC_MOD_OFF;
      upper_ff <= `MRC_RST_UPPER;
      lower_ff <= `MRC_RST_LOWER;
      target_ff <= 32'sh0;
      loop_len_ff <= 32'sh0;
      cmd_ff <= 16'h0000;
      timeout_ff <= `MRC_RST_TIMEOUT;
    end else if (wr_ok) begin
      if (wr_mode) mode_ff <= mrc_mode_t'(s_axi_wdata[2:0]);
      if (wr_upper) upper_ff <= wval;
      if (wr_lower) lower_ff <= wval;
      if (wr_target) target_ff <= wval;
      if (wr_loop) loop_len_ff <= wval;
      if (wr_cmd) cmd_ff <= cmd_new;
      if (wr_tmo) timeout_ff <= s_axi_wdata[15:0];
    end
  end

  // run set storage, one entry per set
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_set
      wire hit = wr_ok && wr_set && (wr_set_idx == 2'(g));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sets_ff[g] <= '{`MRC_RST_WINDOW, `MRC_RST_SPEED, `MRC_RST_ABORT_MS,
                          `MRC_RST_ABORT_PCT, `MRC_RST_CUR, `MRC_RST_CUR, `MRC_RST_ST_MS};
        end else if (hit) begin
          unique case (wr_word)
            2'h0: sets_ff[g].window <= s_axi_wdata;
            2'h1: {sets_ff[g].abort_ms, sets_ff[g].speed} <= s_axi_wdata;
            2'h2: {sets_ff[g].st_cur, sets_ff[g].op_cur, sets_ff[g].abort_pct}
                    <= {s_axi_wdata[31:16], s_axi_wdata[7:0]};
            2'h3: sets_ff[g].st_ms <= s_axi_wdata[15:0];
          endcase
        end
      end
    end
  endgenerate

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_bad ? 2'h2 : 2'h0;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // millisecond divider, free running
  always_ff @(posedge aclk) begin
    if (!aresetn || ms_tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  // telegram age; saturates so a long silence stays lost
  always_ff @(posedge aclk) begin
    if (!aresetn || telegram_rx) begin
      ms_since_ff <= 16'h0000;
    end else if (ms_tick && ms_since_ff != 16'hFFFF) begin
      ms_since_ff <= ms_since_ff + 16'h0001;
    end
  end

  // link lost flag: follows lost_now each cycle, so a sign of life or a timeout write that ends lost_now clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_lost_ff <= 1'b0;
    end else begin
      link_lost_ff <= lost_now;
    end
  end

  // stall timer counts milliseconds of slow running
  always_ff @(posedge aclk) begin
    if (!aresetn || state_ff != MRC_RUN || !slow) begin
      stall_ms_ff <= 16'h0000;
    end else if (ms_tick && stall_ms_ff != 16'hFFFF) begin
      stall_ms_ff <= stall_ms_ff + 16'h0001;
    end
  end

  // run sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= MRC_IDLE;
      dist_ff <= 32'sh0;
      manual_ff <= 1'b0;
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
      pos_err_ff <= 1'b0;
      startup_ff <= '{`MRC_RST_CUR, `MRC_RST_ST_MS};
    end else begin
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
      unique case (state_ff)
        MRC_IDLE: begin
          if (go_man || go_pos) begin
            state_ff <= MRC_RUN;
            start_ff <= 1'b1;
            manual_ff <= go_man;
            dist_ff <= go_man ? man_dist : pos_dist;
            pos_err_ff <= 1'b0;
            startup_ff <= '{cur_set.st_cur, cur_set.st_ms};
          end
        end
        MRC_RUN: begin
          if (abort_now) begin
            state_ff <= MRC_IDLE;
            abort_ff <= 1'b1;
            pos_err_ff <= 1'b1;
          end else if (run_done) begin
            state_ff <= MRC_IDLE;
          end
        end
      endcase
    end
  end

  assign run_start = start_ff;
  assign run_abort = abort_ff;
  assign run_active = (state_ff == MRC_RUN);
  assign run_dist = dist_ff;
  assign run_manual = manual_ff;

  // read decode
  wire [7:0] ra = s_axi_araddr;
  wire rd_set = (ra[7:6] == `MRC_SET_PAGE);
  wire mrc_set_t rs = sets_ff[ra[5:4]];
  wire [31:0] status_w = (32'(link_ok) << `MRC_ST_LINK_OK)
                         | (32'(run_active) << `MRC_ST_MOVING)
                         | (32'(pos_err_ff) << `MRC_ST_POS_ERR);
  logic [31:0] rd_mux;
  logic rd_err;
  always_comb begin
    rd_mux = 32'h0;
    rd_err = 1'b0;
    if (rd_set) begin
      unique case (ra[3:2])
        2'h0: rd_mux = rs.window;
        2'h1: rd_mux = {rs.abort_ms, rs.speed};
        2'h2: rd_mux = {rs.st_cur, rs.op_cur, 8'h00, rs.abort_pct};
        2'h3: rd_mux = {16'h0000, rs.st_ms};
      endcase
    end else begin
      unique case (ra)
        `MRC_OFS_MODE: rd_mux = {29'h0, mode_ff};
        `MRC_OFS_UPPER: rd_mux = upper_ff;
        `MRC_OFS_LOWER: rd_mux = lower_ff;
        `MRC_OFS_CMD: rd_mux = {16'h0000, cmd_ff};
        `MRC_OFS_TARGET: rd_mux = target_ff;
        `MRC_OFS_TIMEOUT: rd_mux = {16'h0000, timeout_ff};
        `MRC_OFS_LOOPLEN: rd_mux = loop_len_ff;
        `MRC_OFS_STATUS: rd_mux = status_w;
        `MRC_OFS_ACTPOS: rd_mux = act_pos;
        `MRC_OFS_RUNDIST: rd_mux = dist_ff;
        default: rd_err = 1'b1;
      endcase
    end
  end

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // read data, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= 2'h0;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_err ? 2'h2 : 2'h0;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- testbench/mrc_run_chk.sv
// Purpose: port-level checks of the run control
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound into every run control instance
`timescale 1ns/1ps
`default_nettype none
module mrc_run_chk
  import mrc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // run sequencing
  input wire logic run_done,
  input wire logic run_start,
  input wire logic run_active,
  input wire logic run_abort,
  input wire mrc_startup_t startup_live
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // answers follow the take and stand until accepted
  property p_w_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid |=> s_axi_bvalid;
  endproperty
  a_w_answer: assert property (p_w_answer) else $error("write response missing");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read data missing");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  // a start is one pulse, caused by a taken write, and raises the moving flag
  property p_start;
    run_start |-> run_active ##1 !run_start;
  endproperty
  a_start: assert property (p_start) else $error("start pulse malformed");
  property p_start_cause;
    run_start |-> $past(s_axi_awvalid && s_axi_awready && !s_axi_bvalid);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without write");
  property p_done;
    run_active && run_done && !run_abort |=> !run_active;
  endproperty
  a_done: assert property (p_done) else $error("run did not end");
  property p_abort;
    run_abort |-> ##[0:1] !run_active;
  endproperty
  a_abort: assert property (p_abort) else $error("abort left run active");
  // start-up values must not follow a set change inside a run
  property p_startup;
    run_active && !run_start |-> $stable(startup_live);
  endproperty
  a_startup: assert property (p_startup) else $error("start-up values moved mid-run");

  c_start: cover property (run_start);
  c_abort: cover property (run_abort);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind mrc_run_ctrl mrc_run_chk i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .run_done, .run_start,
  .run_active, .run_abort, .startup_live);
`default_nettype wire

//--- testbench/mrc_motor_model.sv
// Purpose: behavioural motor loop in front of the run control
// Assumes: runs end after a fixed delay unless stalled
// Notes: slow runs outlast several bus writes
`timescale 1ns/1ps
`default_nettype none
module mrc_motor_model
  import mrc_pkg::*;
#(
  parameter int FAST = 2,
  parameter int SLOW = 80
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // run control side
  input wire logic run_start,
  input wire logic run_active,
  input wire logic signed [31:0] run_dist,
  input wire mrc_set_t set_live,
  output logic signed [31:0] enc_pos,
  output logic [15:0] speed_act,
  output logic run_done,
  // bench controls
  input wire logic slow,
  input wire logic stall,
  input wire logic preset,
  input wire logic signed [31:0] preset_val
);
  logic [7:0] cnt_ff;
  logic signed [31:0] dist_ff;

  // a stalled or idle shaft reports zero speed, otherwise the set speed
  assign speed_act = (run_active && !stall) ? set_live.speed : 16'h0000;

  // count down, then move the encoder by the distance
  always_ff @(posedge aclk) begin
    run_done <= 1'b0;
    if (!aresetn) begin
      cnt_ff <= 8'h00;
      enc_pos <= 32'h0000_0000;
    end else if (preset) begin
      enc_pos <= preset_val;
    end else if (run_start) begin
      cnt_ff <= slow ? 8'(SLOW) : 8'(FAST);
      dist_ff <= run_dist;
    end else if (run_active && !stall && cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
      if (cnt_ff == 8'h01) begin
        run_done <= 1'b1;
        enc_pos <= enc_pos + dist_ff;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/mrc_run_ctrl_tb.sv
// Purpose: self-checking bench of the modulo run control
// Assumes: modulo range 0 to 360, millisecond shortened to 10 cycles
// Notes: fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none
module mrc_run_ctrl_tb
  import mrc_pkg::*;
;
  localparam int MS = 10;
  localparam int W = 360;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_arready, s_axi_rvalid, link_up, telegram_rx, slow, stall, preset;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic signed [31:0] preset_val, enc_pos, run_dist, p, t;
  logic [15:0] speed_act;
  logic run_done, run_start, run_active, run_abort, run_manual, adj_dir_neg, ref_loop_en;
  mrc_set_t set_live;
  mrc_startup_t startup_live;
  logic [31:0] xs = 32'h0000_F5D6;
  int n_mismatch = 0;
  int compares = 0;
  int n_abort = 0;
  int cnt, a0;
  int pv[4] = '{359, 360, -1, 725};

  always #25 aclk = ~aclk;

  mrc_run_ctrl #(.MS_CYC(MS)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_up, .telegram_rx, .enc_pos, .speed_act,
    .run_done, .run_start, .run_active, .run_abort, .run_dist, .run_manual, .set_live,
    .startup_live, .adj_dir_neg, .ref_loop_en);
  mrc_motor_model i_mot (.aclk, .aresetn, .run_start, .run_active, .run_dist, .set_live,
    .enc_pos, .speed_act, .run_done, .slow, .stall, .preset, .preset_val);

  // count aborts seen at the ports
  always @(posedge aclk) if (run_abort) n_abort <= n_abort + 1;

  function automatic logic [31:0] xsh(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic signed [31:0] fold(input logic signed [31:0] v);
    return (v % W + W) % W;
  endfunction
  // expected distance per sub-mode, window of one
  function automatic logic signed [31:0] exp_dist(input int md, input logic signed [31:0] tg, ps);
    logic signed [31:0] u;
    u = fold(fold(tg) - ps);
    case (md)
      1: return u;
      2: return u == 0 ? 0 : u - W;
      3: return u > W / 2 ? u - W : u;
      4: return (u != 0 && W - u <= 1) ? u - W : u;
      default: return (u <= 1) ? u : u - W;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ready comes one edge late, so answers are seen to stand
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready && !s_axi_bvalid));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  // clear run bits first so the next write is an edge
  task automatic run(input logic [31:0] c);
    wr(8'h0C, c & 32'h0000_0300);
    wr(8'h0C, c);
  endtask
  task automatic idle();
    do @(posedge aclk); while (run_active);
    @(posedge aclk);
  endtask
  task automatic tg();
    telegram_rx <= 1'b1;
    @(posedge aclk);
    telegram_rx <= 1'b0;
  endtask
  task automatic final_report();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // runs need well under this
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    $display("[ERR] watchdog expected finish seen hang");
    final_report();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, telegram_rx, slow, stall, preset} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, preset_val} = '0;
    link_up = 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00); chk("mode", 0, rv);
    rd(8'h04); chk("upper", 32'h0000_0168, rv);
    wr(8'h04, 0); chk("upper_low", 2, rs);
    wr(8'h08, 32'h0000_0168); chk("lower_high", 2, rs);
    wr(8'h00, 6); chk("mode_bad", 2, rs);
    rd(8'h04); chk("upper_kept", 32'h0000_0168, rv);
    rd(8'h3C); chk("unmapped", 2, rs);
    // reported position wraps at both ends
    wr(8'h00, 1);
    for (int i = 0; i < 4; i++) begin
      preset_val <= pv[i];
      preset <= 1'b1;
      @(posedge aclk);
      preset <= 1'b0;
      rd(8'h20); chk("act_pos", fold(pv[i]), rv);
    end
    // each sub-mode 1 to 5, edge and random targets
    for (int m = 1; m < 6; m++) begin
      wr(8'h00, m);
      for (int k = 0; k < 6; k++) begin
        p = fold(enc_pos);
        xs = xsh(xs);
        t = k == 0 ? p - 1 : k == 1 ? p + 1 : k == 2 ? 450 : $signed(xs % 2000) - 1000;
        wr(8'h10, t);
        run(4);
        if (m != 3 || fold(fold(t) - p) != W / 2) chk("dist", exp_dist(m, t, p), run_dist);
        idle();
      end
    end
    run(1); chk("man_up", W, run_dist);
    chk("man_flag", 1, run_manual);
    rd(8'h1C); chk("moving", 1, rv[6]);
    idle();
    run(2); chk("man_dn", -W, run_dist);
    idle();
    wr(8'h18, -5); chk("adj_neg", 1, adj_dir_neg);
    chk("ref_mod", 0, ref_loop_en);
    wr(8'h00, 0); chk("ref_off", 1, ref_loop_en);
    // set values at once, start-up values at next run
    for (int s = 0; s < 4; s++) begin
      wr(8'h40 + 8'(s * 16), 100 + s);
      wr(8'h4C + 8'(s * 16), 10 + s);
    end
    slow <= 1'b1;
    run(4);
    for (int s = 0; s < 4; s++) begin
      wr(8'h0C, s << 8);
      chk("window", 100 + s, set_live.window);
      chk("st_ms", 10, startup_live.st_ms);
    end
    idle();
    run(32'h0000_0304); chk("st_ms_next", 13, startup_live.st_ms);
    idle();
    // stalled shaft gives up after 200 ms; the ms tick adds up to one ms
    stall <= 1'b1;
    slow <= 1'b0;
    run(32'h0000_0304);
    for (cnt = 0; !run_abort; cnt++) @(posedge aclk);
    chk("stall_time", 1, cnt > 200 * MS && cnt <= 201 * MS + 2);
    rd(8'h1C); chk("pos_err", 32'h0000_0400, rv & 32'h0000_0440);
    stall <= 1'b0;
    // zero timeout: run finishes, later starts refused
    slow <= 1'b1;
    run(4);
    link_up <= 1'b0;
    a0 = n_abort;
    idle(); chk("finished", a0, n_abort);
    run(4); chk("blocked", 0, run_active);
    link_up <= 1'b1;
    repeat (2) @(posedge aclk);
    // nonzero timeout: silence aborts, blocks until a telegram
    wr(8'h14, 5);
    tg();
    run(4);
    idle(); chk("tmo_abort", a0 + 1, n_abort);
    run(4); chk("tmo_block", 0, run_active);
    tg();
    run(4); chk("restored", 1, run_active);
    wr(8'h14, 0);
    idle();
    final_report();
  end
endmodule
`default_nettype wire
